// ===== inc/regulator_pkg.sv
/*
  Shared constants and types for the regulator mode sequencer and its
  serial register target. Assumes a 40 MHz system clock and a separate,
  free-running link clock that oversamples the two-wire bus pins.
*/
package regulator_pkg;

  // system clock and start-up timing
  localparam int CLK_HZ       = 40_000_000;
  localparam int INIT_TIME_US = 400;
  localparam int INIT_CYCLES  = (CLK_HZ / 1_000_000) * INIT_TIME_US;

  // register indices, one byte each
  localparam logic [7:0] REG_SETPOINT = 8'h00;
  localparam logic [7:0] REG_CONTROL1 = 8'h01;
  localparam logic [7:0] REG_CONTROL2 = 8'h02;
  localparam logic [7:0] REG_CONTROL3 = 8'h03;
  localparam logic [7:0] REG_STATUS   = 8'h04;

  // reset values, read and write masks
  localparam logic [7:0] CONTROL1_RST   = 8'h2A;
  localparam logic [7:0] CONTROL2_RST   = 8'h09;
  localparam logic [7:0] CONTROL3_RST   = 8'h00;
  localparam logic [7:0] CONTROL1_RMASK = 8'h7F;
  localparam logic [7:0] CONTROL2_WMASK = 8'h0F;
  localparam logic [7:0] CONTROL3_WMASK = 8'h03;
  localparam logic [7:0] READ_UNMAPPED  = 8'h00;

  // field positions
  localparam int C1_RESET_BIT  = 7;
  localparam int C1_SWITCHING_ENABLE_BIT_BIT   = 5;
  localparam int C1_DISCH_BIT  = 3;
  localparam int C3_SINGLE_BIT = 1;
  localparam int ST_ILIM_BIT   = 4;
  localparam int ST_TSHUT_BIT  = 2;

  // serial framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT   = 4'h7;
  localparam logic [6:0] GENERAL_CALL  = 7'h00;

  typedef enum logic [2:0] {
    M_POR, M_UNDERVOLTAGE_LOCKOUT, M_INIT, M_STANDBY, M_ON
  } mode_t;

  typedef enum logic [2:0] {
    P_IDLE, P_ADDR, P_REG, P_DATA, P_READ
  } phase_t;

  // analog comparator, stack and strap pins seen by the sequencer
  typedef struct packed {
    logic       por_ok;
    logic       undervoltage_lockout_ok;
    logic       overvoltage_lockout;
    logic       tshut;
    logic       ilim;
    logic       stack_ready;
    logic [1:0] freq_strap;
    logic [1:0] volt_strap;
    logic       chain_strap;
  } pins_t;

  // power-stage controls
  typedef struct packed {
    logic switching;
    logic discharge;
    logic amp_clamp;
  } power_ctl_t;

endpackage

// ===== verilog/regulator_core.sv
/*
  Mode sequencer and serial register target of a stackable buck
  regulator core. Assumes comparator and strap levels arrive as
  asynchronous pins, the bus pins are sampled on a free-running link
  clock much faster than the bus clock, and the shared stack-ready line
  and data line are open-drain with external pull-ups.
*/
module regulator_core #(
  parameter logic [6:0] ADDR_BASE    = 7'h40,
  parameter logic [7:0] SETPOINT_RST = 8'h00,
  parameter int         INIT_CYCLES  = regulator_pkg::INIT_CYCLES
) (
  input  wire logic                      clock,           // 40 MHz system
  input  wire logic                      reset_n,         // sync, low
  input  wire logic                      link_clock,      // bus sampler
  input  wire regulator_pkg::pins_t      pins,            // async levels
  input  wire logic                      scl_in,          // bus clock pin
  input  wire logic                      sda_in,          // bus data pin
  output logic                           sda_out,         // always low
  output logic                           sda_oe,          // pull data low
  output logic                           stack_ready_out, // always low
  output logic                           stack_ready_oe,  // pull ready low
  output regulator_pkg::mode_t           mode,            // current mode
  output regulator_pkg::power_ctl_t      power_ctl,       // stage controls
  output logic [1:0]                     freq_sel,        // latched strap
  output logic                           secondary,       // latched strap
  output logic [7:0]                     setpoint         // link domain
);

  if (INIT_CYCLES < 1) begin : g_chk
    $error("INIT_CYCLES must be at least one");
  end

  localparam int CW = $clog2(INIT_CYCLES + 1);

  // system clock domain: input synchronisers
  regulator_pkg::pins_t pin_s1_q;
  regulator_pkg::pins_t pin_q;
  logic [2:0]           cfg_s1_q;
  logic [2:0]           cfg_q;
  logic [2:0]           rtg_s_q;

  // link domain signals crossing into the system domain
  logic                 rst_tgl_q;
  logic                 switching_enable_bit_l;
  logic                 disch_l;
  logic                 single_l;

  always_ff @(posedge clock) begin
    pin_s1_q <= pins;
    pin_q    <= pin_s1_q;
    cfg_s1_q <= {single_l, disch_l, switching_enable_bit_l};
    cfg_q    <= cfg_s1_q;
    rtg_s_q  <= {rtg_s_q[1:0], rst_tgl_q};
  end

  logic switching_enable_bit_s;
  logic disch_s;
  logic single_s;
  logic reg_reset_ev;
  logic run_ok;

  assign switching_enable_bit_s       = cfg_q[0];
  assign disch_s      = cfg_q[1];
  assign single_s     = cfg_q[2];
  assign reg_reset_ev = rtg_s_q[2] ^ rtg_s_q[1];
  // every condition besides the supply levels that must hold for switching
  assign run_ok = pin_q.stack_ready && switching_enable_bit_s &&
                  !pin_q.tshut && !pin_q.overvoltage_lockout;

  // mode sequencer
  regulator_pkg::mode_t mode_q;
  logic [CW-1:0]        init_cnt_q;
  logic                 initialized_q;
  logic                 from_standby_q;
  logic [1:0]           volt_code_q;
  logic                 init_done_q;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mode_q         <= regulator_pkg::M_POR;
      init_cnt_q     <= '0;
      initialized_q  <= 1'b0;
      from_standby_q <= 1'b0;
    end else if (!pin_q.por_ok) begin
      mode_q         <= regulator_pkg::M_POR;
      initialized_q  <= 1'b0;
      from_standby_q <= 1'b0;
      init_cnt_q     <= '0;
    end else begin
      case (mode_q)
        regulator_pkg::M_POR: begin
          mode_q <= regulator_pkg::M_UNDERVOLTAGE_LOCKOUT;
        end
        regulator_pkg::M_UNDERVOLTAGE_LOCKOUT: begin
          if (pin_q.undervoltage_lockout_ok) begin
            init_cnt_q <= '0;
            // a dip above the reset threshold skips the init
            mode_q <= initialized_q ? regulator_pkg::M_STANDBY
                                    : regulator_pkg::M_INIT;
          end
        end
        regulator_pkg::M_INIT: begin
          if (!pin_q.undervoltage_lockout_ok) begin
            mode_q <= regulator_pkg::M_UNDERVOLTAGE_LOCKOUT;
          end else if (init_cnt_q == CW'(INIT_CYCLES - 1)) begin
            mode_q        <= regulator_pkg::M_STANDBY;
            initialized_q <= 1'b1;
          end else begin
            init_cnt_q <= init_cnt_q + 1'b1;
          end
        end
        regulator_pkg::M_STANDBY: begin
          if (!pin_q.undervoltage_lockout_ok) begin
            mode_q         <= regulator_pkg::M_UNDERVOLTAGE_LOCKOUT;
            from_standby_q <= 1'b1;
          end else if (reg_reset_ev) begin
            mode_q     <= regulator_pkg::M_INIT;
            init_cnt_q <= '0;
          end else if (run_ok) begin
            mode_q <= regulator_pkg::M_ON;
          end
        end
        regulator_pkg::M_ON: begin
          if (!pin_q.undervoltage_lockout_ok) begin
            mode_q         <= regulator_pkg::M_UNDERVOLTAGE_LOCKOUT;
            from_standby_q <= 1'b1;
          end else if (reg_reset_ev) begin
            mode_q     <= regulator_pkg::M_INIT;
            init_cnt_q <= '0;
          end else if (!run_ok) begin
            mode_q <= regulator_pkg::M_STANDBY;
          end
        end
        default: begin
          mode_q <= regulator_pkg::M_POR;
        end
      endcase
    end
  end

  // straps are caught on the last init cycle, after synchronisation
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      volt_code_q <= 2'h0;
      freq_sel    <= 2'h0;
      secondary   <= 1'b0;
    end else if (mode_q == regulator_pkg::M_INIT &&
                 init_cnt_q == CW'(INIT_CYCLES - 1)) begin
      volt_code_q <= pin_q.volt_strap;
      freq_sel    <= pin_q.freq_strap;
      secondary   <= pin_q.chain_strap;
    end
  end

  // qualifies volt_code_q for the link domain; the code is stable while high
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      init_done_q <= 1'b0;
    end else begin
      init_done_q <= mode_q == regulator_pkg::M_STANDBY ||
                     mode_q == regulator_pkg::M_ON;
    end
  end

  // outputs of the system domain
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mode            <= regulator_pkg::M_POR;
      power_ctl       <= '0;
      stack_ready_oe  <= 1'b0;
      stack_ready_out <= 1'b0;
    end else begin
      mode                <= mode_q;
      stack_ready_out     <= 1'b0;
      power_ctl.switching <= mode_q == regulator_pkg::M_ON;
      // discharge never in reset or in a lockout entered from reset
      power_ctl.discharge <= disch_s &&
        (mode_q == regulator_pkg::M_STANDBY ||
         (mode_q == regulator_pkg::M_UNDERVOLTAGE_LOCKOUT && from_standby_q));
      // current limit stays local: no pull on the ready line
      power_ctl.amp_clamp <= pin_q.ilim &&
                             mode_q == regulator_pkg::M_ON;
      // init counts as a fault so the stack waits for every member
      stack_ready_oe <= !single_s && mode_q != regulator_pkg::M_POR &&
        (mode_q == regulator_pkg::M_UNDERVOLTAGE_LOCKOUT ||
         mode_q == regulator_pkg::M_INIT ||
         pin_q.overvoltage_lockout || pin_q.tshut);
    end
  end

  // link clock domain: reset and pin synchronisers
  logic [1:0] lrst_q;
  logic [5:0] ls1_q;
  logic [5:0] ls2_q;
  logic       scl_prev_q;
  logic       sda_prev_q;
  logic       lrst_n;

  always_ff @(posedge link_clock) begin
    lrst_q     <= {lrst_q[0], reset_n};
    ls1_q      <= {init_done_q, pins.tshut, pins.ilim, pins.por_ok,
                   sda_in, scl_in};
    ls2_q      <= ls1_q;
    scl_prev_q <= ls2_q[0];
    sda_prev_q <= ls2_q[1];
  end

  logic scl;
  logic sda;
  logic lpor;
  logic lilim;
  logic ltshut;
  logic linit;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [6:0] own_addr;

  assign lrst_n   = lrst_q[1];
  assign scl      = ls2_q[0];
  assign sda      = ls2_q[1];
  assign lpor     = ls2_q[2];
  assign lilim    = ls2_q[3];
  assign ltshut   = ls2_q[4];
  assign linit    = ls2_q[5];
  assign scl_rise = scl && !scl_prev_q;
  assign scl_fall = !scl && scl_prev_q;
  assign start_cond = scl && scl_prev_q && sda_prev_q && !sda;
  assign stop_cond  = scl && scl_prev_q && !sda_prev_q && sda;
  assign own_addr   = ADDR_BASE + {5'h00, volt_code_q};

  // register file
  logic [7:0] setpoint_q;
  logic [7:0] control1_q;
  logic [7:0] control2_q;
  logic [7:0] control3_q;
  logic       wr_stb_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;

  assign switching_enable_bit_l   = control1_q[regulator_pkg::C1_SWITCHING_ENABLE_BIT_BIT];
  assign disch_l  = control1_q[regulator_pkg::C1_DISCH_BIT];
  assign single_l = control3_q[regulator_pkg::C3_SINGLE_BIT];
  assign setpoint = setpoint_q;

  function automatic logic [7:0] reg_read(input logic [7:0] idx);
    logic [7:0] st;
    st = '0;
    st[regulator_pkg::ST_ILIM_BIT]  = lilim;
    st[regulator_pkg::ST_TSHUT_BIT] = ltshut;
    case (idx)
      regulator_pkg::REG_SETPOINT: reg_read = setpoint_q;
      // the reset bit never reads back set
      regulator_pkg::REG_CONTROL1:
        reg_read = control1_q & regulator_pkg::CONTROL1_RMASK;
      regulator_pkg::REG_CONTROL2: reg_read = control2_q;
      regulator_pkg::REG_CONTROL3: reg_read = control3_q;
      regulator_pkg::REG_STATUS:   reg_read = st;
      default: reg_read = regulator_pkg::READ_UNMAPPED;
    endcase
  endfunction

  always_ff @(posedge link_clock) begin
    if (!lrst_n || !lpor) begin
      setpoint_q <= SETPOINT_RST;
      control1_q <= regulator_pkg::CONTROL1_RST;
      control2_q <= regulator_pkg::CONTROL2_RST;
      control3_q <= regulator_pkg::CONTROL3_RST;
    end else if (wr_stb_q) begin
      case (wr_addr_q)
        regulator_pkg::REG_SETPOINT: setpoint_q <= wr_data_q;
        regulator_pkg::REG_CONTROL1: begin
          if (wr_data_q[regulator_pkg::C1_RESET_BIT]) begin
            setpoint_q <= SETPOINT_RST;
            control1_q <= regulator_pkg::CONTROL1_RST;
            control2_q <= regulator_pkg::CONTROL2_RST;
            control3_q <= regulator_pkg::CONTROL3_RST;
          end else begin
            control1_q <= wr_data_q;
          end
        end
        regulator_pkg::REG_CONTROL2:
          control2_q <= wr_data_q & regulator_pkg::CONTROL2_WMASK;
        regulator_pkg::REG_CONTROL3:
          control3_q <= wr_data_q & regulator_pkg::CONTROL3_WMASK;
        default: begin
        end
      endcase
    end
  end

  // a toggle carries the restart request to the sequencer
  always_ff @(posedge link_clock) begin
    if (!lrst_n) begin
      rst_tgl_q <= 1'b0;
    end else if (wr_stb_q && wr_addr_q == regulator_pkg::REG_CONTROL1 &&
                 wr_data_q[regulator_pkg::C1_RESET_BIT]) begin
      rst_tgl_q <= ~rst_tgl_q;
    end
  end

  // serial target engine; bits in on clock rise, data out on clock fall
  regulator_pkg::phase_t phase_q;
  logic       ack_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic [7:0] rd_byte;
  logic [7:0] nxt_byte;
  logic       nack_q;

  assign rd_byte  = reg_read(ptr_q);
  assign nxt_byte = reg_read(ptr_q + 8'h01);

  // open-drain: the pin only ever pulls low, gated by sda_oe
  always_ff @(posedge link_clock) begin
    sda_out <= 1'b0;
  end

  always_ff @(posedge link_clock) begin
    wr_stb_q <= 1'b0;
    if (!lrst_n) begin
      phase_q   <= regulator_pkg::P_IDLE;
      ack_q     <= 1'b0;
      cnt_q     <= 4'h0;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      ptr_q     <= 8'h00;
      nack_q    <= 1'b0;
      sda_oe    <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else if (start_cond) begin
      // a repeated start keeps the register pointer
      phase_q <= regulator_pkg::P_ADDR;
      ack_q   <= 1'b0;
      cnt_q   <= 4'h0;
      sda_oe  <= 1'b0;
    end else if (stop_cond) begin
      phase_q <= regulator_pkg::P_IDLE;
      ack_q   <= 1'b0;
      sda_oe  <= 1'b0;
    end else if (scl_rise) begin
      if (phase_q == regulator_pkg::P_READ) begin
        if (ack_q) begin
          nack_q <= sda;
        end
      end else if (phase_q != regulator_pkg::P_IDLE && !ack_q) begin
        shift_q <= {shift_q[6:0], sda};
        cnt_q   <= cnt_q + 1'b1;
      end
    end else if (scl_fall) begin
      if (phase_q == regulator_pkg::P_READ) begin
        if (!ack_q) begin
          if (cnt_q == regulator_pkg::LAST_TX_BIT) begin
            sda_oe <= 1'b0;                  // controller acks this byte
            ack_q  <= 1'b1;
          end else begin
            tx_q   <= {tx_q[6:0], 1'b0};
            sda_oe <= !tx_q[6];
            cnt_q  <= cnt_q + 1'b1;
          end
        end else if (nack_q) begin
          phase_q <= regulator_pkg::P_IDLE;  // wait for stop or start
          ack_q   <= 1'b0;
        end else begin
          ptr_q  <= ptr_q + 1'b1;
          tx_q   <= nxt_byte;
          sda_oe <= !nxt_byte[7];
          cnt_q  <= 4'h0;
          ack_q  <= 1'b0;
        end
      end else if (phase_q != regulator_pkg::P_IDLE && !ack_q &&
                   cnt_q == regulator_pkg::BITS_PER_BYTE) begin
        if (phase_q == regulator_pkg::P_ADDR &&
            (shift_q[7:1] != own_addr || !linit ||
             shift_q[7:1] == regulator_pkg::GENERAL_CALL)) begin
          phase_q <= regulator_pkg::P_IDLE;
        end else begin
          ack_q  <= 1'b1;
          sda_oe <= 1'b1;
        end
      end else if (ack_q) begin
        ack_q  <= 1'b0;
        sda_oe <= 1'b0;
        cnt_q  <= 4'h0;
        case (phase_q)
          regulator_pkg::P_ADDR: begin
            if (shift_q[0]) begin
              phase_q <= regulator_pkg::P_READ;
              tx_q    <= rd_byte;
              sda_oe  <= !rd_byte[7];
            end else begin
              phase_q <= regulator_pkg::P_REG;
            end
          end
          regulator_pkg::P_REG: begin
            ptr_q   <= shift_q;
            phase_q <= regulator_pkg::P_DATA;
          end
          regulator_pkg::P_DATA: begin
            // applied as the acknowledge clock falls
            wr_stb_q  <= 1'b1;
            wr_addr_q <= ptr_q;
            wr_data_q <= shift_q;
            ptr_q     <= ptr_q + 1'b1;
          end
          default: begin
            phase_q <= regulator_pkg::P_IDLE;
          end
        endcase
      end
    end
  end

  // the engine relies on link_clock sampling the bus at least four
  // times per bus clock high phase; a stop returns the engine to idle.

endmodule

// ===== verif/regulator_core_sva.sv
/*
  Port checks on the regulator core in the system clock domain.
  Assumes it is bound into every regulator_core instance.
*/
module regulator_core_sva #(
  parameter int INIT_CYCLES = regulator_pkg::INIT_CYCLES
) (
  input wire logic                      clock,          // system clock
  input wire logic                      reset_n,        // sync, low
  input wire regulator_pkg::pins_t      pins,           // pin levels
  input wire logic                      stack_ready_oe, // ready pull
  input wire regulator_pkg::mode_t      mode,           // current mode
  input wire regulator_pkg::power_ctl_t power_ctl       // stage controls
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  int init_cnt_q;
  // too long for a repetition, so start-up samples are counted here
  always_ff @(posedge clock) begin
    if (!reset_n || mode != regulator_pkg::M_INIT)
      init_cnt_q <= 0;
    else
      init_cnt_q <= init_cnt_q + 1;
  end
  sequence s_init_done;
    $fell(mode == regulator_pkg::M_INIT) ##0 mode == regulator_pkg::M_STANDBY;
  endsequence
  property p_por;
    !pins.por_ok [*8] |-> mode == regulator_pkg::M_POR;
  endproperty
  a_por: assert property (p_por)
    else $error("not in reset mode");
  property p_por_off;
    mode == regulator_pkg::M_POR |-> !stack_ready_oe && power_ctl == 3'h0;
  endproperty
  a_por_off: assert property (p_por_off)
    else $error("output active in reset mode");
  property p_undervoltage_lockout;
    (pins.por_ok && !pins.undervoltage_lockout_ok) [*8] |-> mode == regulator_pkg::M_UNDERVOLTAGE_LOCKOUT;
  endproperty
  a_undervoltage_lockout: assert property (p_undervoltage_lockout)
    else $error("not in lockout");
  property p_init;
    s_init_done |-> init_cnt_q == INIT_CYCLES;
  endproperty
  a_init: assert property (p_init)
    else $error("start-up length off");
  property p_hot;
    pins.tshut [*8] |-> mode != regulator_pkg::M_ON && !power_ctl.switching;
  endproperty
  a_hot: assert property (p_hot)
    else $error("running while hot");
  property p_ready;
    !pins.stack_ready [*8] |-> mode != regulator_pkg::M_ON;
  endproperty
  a_ready: assert property (p_ready)
    else $error("running with ready line low");
  property p_run;
    power_ctl.switching || power_ctl.amp_clamp |-> mode == regulator_pkg::M_ON;
  endproperty
  a_run: assert property (p_run)
    else $error("stage active outside on mode");
  property p_disch;
    power_ctl.discharge |->
      mode inside {regulator_pkg::M_STANDBY, regulator_pkg::M_UNDERVOLTAGE_LOCKOUT};
  endproperty
  a_disch: assert property (p_disch)
    else $error("discharge in wrong mode");
endmodule
bind regulator_core regulator_core_sva #(.INIT_CYCLES(INIT_CYCLES)) u_sva (
  .clock(clock), .reset_n(reset_n), .pins(pins),
  .stack_ready_oe(stack_ready_oe), .mode(mode), .power_ctl(power_ctl));

// ===== verif/bus_controller.sv
/*
  Behavioural two-wire bus controller facing the regulator core.
  Assumes the bench resolves the data wire with a pull-up.
*/
module bus_controller (
  output logic      scl,      // bus clock, high when idle
  output logic      sda_pull, // high pulls data low
  input  wire logic sda       // resolved data wire
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 500; // quarter bit, 500 kbps
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // data moves only while the clock is low
  task automatic bitx(input logic b, output logic r);
    sda_pull = !b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic start;
    sda_pull = 1'b0;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop;
    sda_pull = 1'b1;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b0;
    #(2 * Q);
  endtask
  // msb first, then the receiver's acknowledge
  task automatic xbyte(input logic [7:0] d, input logic m_ack,
                       output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
      q[i] = r;
    end
    bitx(!m_ack, r);
    ack = !r;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] r, d,
                    output logic ok);
    logic [7:0] x;
    logic k1, k2, k3;
    start();
    xbyte({a, 1'b0}, 1'b0, x, k1);
    xbyte(r, 1'b0, x, k2);
    xbyte(d, 1'b0, x, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  // register byte, repeated start, one byte ended by a refusal
  task automatic rd(input logic [6:0] a, input logic [7:0] r,
                    output logic [7:0] q, output logic ok);
    logic [7:0] x;
    logic k1, k2, k3, k4;
    start();
    xbyte({a, 1'b0}, 1'b0, x, k1);
    xbyte(r, 1'b0, x, k2);
    start();
    xbyte({a, 1'b1}, 1'b0, x, k3);
    xbyte(8'hFF, 1'b0, q, k4);
    stop();
    ok = k1 & k2 & k3;
  endtask
endmodule

// ===== verif/regulator_core_tb.sv
/*
  Self-checking bench for the regulator core: drives pin levels,
  resolves the open-drain wires and talks through the bus controller.
  Assumes the checker arrives by bind.
*/
module regulator_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INIT_N = 200; // outlasts the stop that ends a write
  logic                      clock, reset_n, link_clock, scl, m_pull;
  logic                      sda_oe, sr_oe, sec, ok;
  logic [1:0]                frequency_strap_pin;
  logic [7:0]                setpoint, q;
  wire logic                 sda;
  regulator_pkg::pins_t      pv, pw;
  regulator_pkg::mode_t      mode;
  regulator_pkg::power_ctl_t pc;
  int n_errors = 0;
  int n_tests = 0;
  assign sda = !(m_pull | sda_oe);
  always_comb begin
    pw = pv;
    pw.stack_ready = pv.stack_ready & !sr_oe; // wired ready line
  end
  regulator_core #(.INIT_CYCLES(INIT_N)) DUT (
    .clock(clock), .reset_n(reset_n), .link_clock(link_clock),
    .pins(pw), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .stack_ready_out(), .stack_ready_oe(sr_oe), .mode(mode),
    .power_ctl(pc), .freq_sel(frequency_strap_pin), .secondary(sec), .setpoint(setpoint));
  bus_controller m (.scl(scl), .sda_pull(m_pull), .sda(sda));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    link_clock = 1'b0;
    #7;
    forever #32 link_clock = ~link_clock;
  end
  task automatic chk(input logic [7:0] g, e, input string s);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h", $time, s, g);
    end
  endtask
  task automatic wm(input regulator_pkg::mode_t e);
    for (int i = 0; i < 300 && mode !== e; i++) @(negedge clock);
    chk(8'(mode), 8'(e), "mode");
  endtask
  task automatic t_powerup;
    repeat (10) @(negedge clock);
    wm(regulator_pkg::M_POR);
    pv.por_ok = 1'b1;
    wm(regulator_pkg::M_UNDERVOLTAGE_LOCKOUT);
    chk(8'(pc), 8'h00, "functions");
    pv.undervoltage_lockout_ok = 1'b1;
    wm(regulator_pkg::M_INIT);
    chk({7'h0, sr_oe}, 8'h01, "ready pull");
    wm(regulator_pkg::M_STANDBY);
    chk({5'h0, sec, frequency_strap_pin}, 8'h07, "straps");
    m.stop();
    $display("power-up test done");
  endtask
  task automatic t_bus;
    m.wr(7'h42, regulator_pkg::REG_SETPOINT, 8'hA5, ok);
    chk({7'h0, ok}, 8'h01, "write ack");
    chk(setpoint, 8'hA5, "setpoint");
    m.rd(7'h42, regulator_pkg::REG_CONTROL2, q, ok);
    chk(q, regulator_pkg::CONTROL2_RST, "ctl2");
    m.rd(7'h42, 8'h07, q, ok);
    chk(q, regulator_pkg::READ_UNMAPPED, "unmapped");
    m.wr(7'h41, regulator_pkg::REG_SETPOINT, 8'h11, ok);
    chk({7'h0, ok}, 8'h00, "other address");
    m.wr(regulator_pkg::GENERAL_CALL, 8'h00, 8'h11, ok);
    chk({7'h0, ok}, 8'h00, "general call");
    chk(setpoint, 8'hA5, "no stray write");
    $display("bus test done");
  endtask
  task automatic t_run;
    pv.stack_ready = 1'b1;
    wm(regulator_pkg::M_ON);
    pv.ilim = 1'b1;
    repeat (6) @(negedge clock);
    chk({6'h0, pc.amp_clamp, sr_oe}, 8'h02, "limit");
    pv.ilim = 1'b0;
    pv.tshut = 1'b1;
    wm(regulator_pkg::M_STANDBY);
    chk({7'h0, sr_oe}, 8'h01, "hot");
    repeat (8) @(negedge clock);
    pv.tshut = 1'b0;
    wm(regulator_pkg::M_ON);
    pv.undervoltage_lockout_ok = 1'b0;
    wm(regulator_pkg::M_UNDERVOLTAGE_LOCKOUT);
    chk({6'h0, pc.discharge, sr_oe}, 8'h03, "lockout");
    repeat (8) @(negedge clock);
    pv.undervoltage_lockout_ok = 1'b1;
    ok = 1'b0;
    repeat (30) begin
      @(negedge clock);
      if (mode === regulator_pkg::M_INIT)
        ok = 1'b1;
    end
    chk({7'h0, ok}, 8'h00, "second start-up");
    chk(8'(mode), 8'(regulator_pkg::M_ON), "back on");
    chk(setpoint, 8'hA5, "kept");
    $display("mode test done");
  endtask
  task automatic t_causes;
    m.wr(7'h42, regulator_pkg::REG_CONTROL1, 8'h0A, ok);
    wm(regulator_pkg::M_STANDBY);
    chk({7'h0, pc.switching}, 8'h00, "switch bit");
    m.wr(7'h42, regulator_pkg::REG_CONTROL1, regulator_pkg::CONTROL1_RST, ok);
    wm(regulator_pkg::M_ON);
    pv.overvoltage_lockout = 1'b1;
    wm(regulator_pkg::M_STANDBY);
    chk({7'h0, sr_oe}, 8'h01, "overvoltage");
    pv.overvoltage_lockout = 1'b0;
    wm(regulator_pkg::M_ON);
    $display("standby cause test done");
  endtask
  task automatic t_regreset;
    m.wr(7'h42, regulator_pkg::REG_CONTROL1, 8'hAA, ok);
    wm(regulator_pkg::M_INIT);
    chk(setpoint, 8'h00, "defaults");
    wm(regulator_pkg::M_ON);
    m.rd(7'h42, regulator_pkg::REG_CONTROL1, q, ok);
    chk(q, regulator_pkg::CONTROL1_RST, "ctl1");
    $display("register reset test done");
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    reset_n = 1'b0;
    pv = '0;
    pv.freq_strap = 2'h3;
    pv.volt_strap = 2'h2;
    pv.chain_strap = 1'b1;
    // held past five cycles so the link side sees it too
    repeat (12) @(negedge clock);
    reset_n = 1'b1;
    t_powerup();
    t_bus();
    t_run();
    t_causes();
    t_regreset();
    complete_run();
  end
  initial begin
    #2ms;
    n_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
